// ### verilog/eccpi_top.sv
// Purpose: Feature configuration and cyclic process image of an encoder counter terminal
// Assumes: Coupler writes the output image with a one-cycle strobe; pins synchronous to mclk_i
// Notes: DUAL_VARIANT selects the two-channel flavour, which has no latch or zero input
//
// Design decisions made here: the plain register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "eccpi_params.svh"

// Function
// - Counter-mode bit selects plain up/down counter
// - Full-image bit selects image with octets
// - High-lock bit: gate high locks counter
// - Low-lock bit: gate low locks counter
// - Five bytes each way: octet plus word
// - Input word carries live or latched value
// - Single-channel variant always uses full image
// - Two-channel variant starts in compact image
// - Latch-select clear: live; set: latched
// - Counter mode: B high down, low up
// - Load request loads counter from preset word
module eccpi_top #(
  parameter logic DUAL_VARIANT = 1'b0
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [`ECCPI_ADDR_W-1:0] reg_addr_i,
  input wire logic [`ECCPI_WORD_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`ECCPI_WORD_W-1:0] reg_rdata_o,
  input wire logic image_strobe_i,
  input wire logic [`ECCPI_OCTET_W-1:0] terminal_control_octet_i,
  input wire logic [`ECCPI_WORD_W-1:0] counter_preset_word_i,
  output logic [`ECCPI_OCTET_W-1:0] terminal_status_octet_o,
  output logic [`ECCPI_WORD_W-1:0] counter_readback_word_o,
  output logic full_image_o,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic c_i,
  input wire logic gate_i
);
  import eccpi_pkg::*;

  eccpi_top_state_t st_ff;
  eccpi_top_state_t nxt_st;

  logic full_eff;
  logic [`ECCPI_OCTET_W-1:0] ctrl_eff;
  logic lock;
  logic load_pulse;
  logic latch_pins;
  logic [`ECCPI_WORD_W-1:0] count;
  logic [`ECCPI_WORD_W-1:0] latch_val;
  logic latch_valid;

  // ****************************************************************
  // Image mode and effective control
  // ****************************************************************
  // Single channel ignores the coupler's compact setting
  // Two channel needs the full-image bit
  assign full_eff = ~DUAL_VARIANT | st_ff.feat.full_img;
  // Without octets in the image the control octet reads as idle
  assign ctrl_eff = full_eff ? st_ff.ctrl : 8'h00;
  // Latch and zero inputs exist only on the single-channel flavour
  assign latch_pins = ~DUAL_VARIANT;
  // Gate level lock, either polarity
  assign lock = (st_ff.feat.hi_lock & gate_i) | (st_ff.feat.lo_lock & ~gate_i);
  // Load on the rising edge of the request bit
  assign load_pulse = ctrl_eff[`ECCPI_CB_LOAD_REQ] & ~st_ff.load_q;

  // ****************************************************************
  // Counter core
  // ****************************************************************
  eccpi_counter u_counter (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .a_i(a_i),
    .b_i(b_i),
    .c_i(c_i & latch_pins),
    .gate_i(gate_i),
    .cnt_mode_i(st_ff.feat.cnt_mode),
    .lock_i(lock),
    .load_i(load_pulse),
    .load_val_i(st_ff.preset),
    .en_latch_c_i(ctrl_eff[`ECCPI_CB_EN_LATCH_C] & latch_pins),
    .en_latch_rise_i(ctrl_eff[`ECCPI_CB_EN_LATCH_RISE] & latch_pins),
    .en_latch_fall_i(ctrl_eff[`ECCPI_CB_EN_LATCH_FALL] & latch_pins),
    .clr_on_latch_i(ctrl_eff[`ECCPI_CB_CLR_ON_LATCH] & latch_pins),
    .count_o(count),
    .latch_o(latch_val),
    .latch_valid_o(latch_valid)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    // Feature register write
    if (reg_wr_i && (reg_addr_i == `ECCPI_FEATURE_ADDR)) begin
      nxt_st.feat.cnt_mode = reg_wdata_i[`ECCPI_FEAT_CNT_MODE];
      nxt_st.feat.full_img = reg_wdata_i[`ECCPI_FEAT_FULL_IMG];
      nxt_st.feat.hi_lock = reg_wdata_i[`ECCPI_FEAT_HI_LOCK];
      nxt_st.feat.lo_lock = reg_wdata_i[`ECCPI_FEAT_LO_LOCK];
    end
    // Output image: control octet and preset word
    if (image_strobe_i) begin
      nxt_st.ctrl = terminal_control_octet_i;
      nxt_st.preset = counter_preset_word_i;
    end
    nxt_st.load_q = ctrl_eff[`ECCPI_CB_LOAD_REQ];
    // Acknowledge follows the request once the load has happened
    if (load_pulse) begin
      nxt_st.load_ack = 1'b1;
    end else if (!ctrl_eff[`ECCPI_CB_LOAD_REQ]) begin
      nxt_st.load_ack = 1'b0;
    end
    // Input word: live or latched value
    if (ctrl_eff[`ECCPI_CB_SEL_LATCHED]) begin
      nxt_st.readback = latch_val;
    end else begin
      nxt_st.readback = count;
    end
    // Status octet, all zero in the compact image
    nxt_st.status = 8'h00;
    if (full_eff) begin
      nxt_st.status[`ECCPI_SB_LATCH_VALID] = latch_valid;
      nxt_st.status[`ECCPI_SB_SEL_LATCHED] = ctrl_eff[`ECCPI_CB_SEL_LATCHED];
      nxt_st.status[`ECCPI_SB_LOAD_ACK] = st_ff.load_ack;
      nxt_st.status[`ECCPI_SB_ZERO_IN] = c_i & latch_pins;
      nxt_st.status[`ECCPI_SB_GATE_IN] = gate_i & latch_pins;
    end
    // Register read, data stands one cycle later
    nxt_st.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `ECCPI_FEATURE_ADDR: begin
          nxt_st.rdata[`ECCPI_FEAT_CNT_MODE] = st_ff.feat.cnt_mode;
          nxt_st.rdata[`ECCPI_FEAT_FULL_IMG] = full_eff;
          nxt_st.rdata[`ECCPI_FEAT_HI_LOCK] = st_ff.feat.hi_lock;
          nxt_st.rdata[`ECCPI_FEAT_LO_LOCK] = st_ff.feat.lo_lock;
        end
        `ECCPI_COUNT_ADDR: begin
          nxt_st.rdata = count;
        end
        `ECCPI_LATCH_ADDR: begin
          nxt_st.rdata = latch_val;
        end
        default: begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
      st_ff.feat.cnt_mode <= `ECCPI_FEAT_CNT_MODE_RST;
      st_ff.feat.full_img <= ~DUAL_VARIANT;
      st_ff.feat.hi_lock <= `ECCPI_FEAT_HI_LOCK_RST;
      st_ff.feat.lo_lock <= `ECCPI_FEAT_LO_LOCK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o = st_ff.rdata;
  assign terminal_status_octet_o = st_ff.status;
  assign counter_readback_word_o = st_ff.readback;
  assign full_image_o = full_eff;

endmodule
`default_nettype wire

// ### include/eccpi_params.svh
// Purpose: Offsets, field positions, reset values for the encoder counter image block
// Assumes: Included by its bare name from the package and design files
// Notes: Definitions only
`ifndef ECCPI_PARAMS_SVH
`define ECCPI_PARAMS_SVH

// ****************************************************************
// Register offsets on the plain register port
// ****************************************************************
`define ECCPI_ADDR_W 6
`define ECCPI_FEATURE_ADDR 6'h20
`define ECCPI_COUNT_ADDR 6'h21
`define ECCPI_LATCH_ADDR 6'h22

// ****************************************************************
// Feature register fields
// ****************************************************************
`define ECCPI_FEAT_CNT_MODE 15
`define ECCPI_FEAT_FULL_IMG 6
`define ECCPI_FEAT_HI_LOCK 5
`define ECCPI_FEAT_LO_LOCK 4
`define ECCPI_FEAT_CNT_MODE_RST 1'h0
`define ECCPI_FEAT_HI_LOCK_RST 1'h0
`define ECCPI_FEAT_LO_LOCK_RST 1'h0

// ****************************************************************
// Control octet fields
// ****************************************************************
`define ECCPI_CB_EN_LATCH_C 0
`define ECCPI_CB_SEL_LATCHED 1
`define ECCPI_CB_LOAD_REQ 2
`define ECCPI_CB_EN_LATCH_RISE 3
`define ECCPI_CB_EN_LATCH_FALL 4
`define ECCPI_CB_CLR_ON_LATCH 5

// ****************************************************************
// Status octet fields
// ****************************************************************
`define ECCPI_SB_LATCH_VALID 0
`define ECCPI_SB_SEL_LATCHED 1
`define ECCPI_SB_LOAD_ACK 2
`define ECCPI_SB_ZERO_IN 3
`define ECCPI_SB_GATE_IN 4

// ****************************************************************
// Image sizes and widths
// ****************************************************************
`define ECCPI_IMAGE_BYTES 5
`define ECCPI_WORD_W 32
`define ECCPI_OCTET_W 8

`endif

// ### include/eccpi_pkg.sv
// Purpose: Types shared by the encoder counter image block
// Assumes: Parameter header is on the include path
// Notes: State of each module is one packed struct
`include "eccpi_params.svh"

package eccpi_pkg;

  typedef struct packed {
    logic cnt_mode;
    logic full_img;
    logic hi_lock;
    logic lo_lock;
  } eccpi_feat_t;

  typedef struct packed {
    eccpi_feat_t feat;
    logic [`ECCPI_OCTET_W-1:0] ctrl;
    logic [`ECCPI_WORD_W-1:0] preset;
    logic load_q;
    logic load_ack;
    logic [`ECCPI_OCTET_W-1:0] status;
    logic [`ECCPI_WORD_W-1:0] readback;
    logic [`ECCPI_WORD_W-1:0] rdata;
  } eccpi_top_state_t;

  typedef struct packed {
    logic [`ECCPI_WORD_W-1:0] cnt;
    logic [`ECCPI_WORD_W-1:0] latch;
    logic latch_valid;
    logic armed;
    logic en_q;
    logic a_q;
    logic b_q;
    logic c_q;
    logic gate_q;
  } eccpi_cnt_state_t;

endpackage

// ### verilog/eccpi_counter.sv
// Purpose: 32-bit position counter with quadrature or up/down counting, lock and latch
// Assumes: Pin inputs are synchronous to mclk_i
// Notes: Load has priority over latch clear, which has priority over counting
`timescale 1ns/1ps
`default_nettype none
`include "eccpi_params.svh"

module eccpi_counter (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic c_i,
  input wire logic gate_i,
  input wire logic cnt_mode_i,
  input wire logic lock_i,
  input wire logic load_i,
  input wire logic [`ECCPI_WORD_W-1:0] load_val_i,
  input wire logic en_latch_c_i,
  input wire logic en_latch_rise_i,
  input wire logic en_latch_fall_i,
  input wire logic clr_on_latch_i,
  output logic [`ECCPI_WORD_W-1:0] count_o,
  output logic [`ECCPI_WORD_W-1:0] latch_o,
  output logic latch_valid_o
);
  import eccpi_pkg::*;

  eccpi_cnt_state_t st_ff;
  eccpi_cnt_state_t nxt_st;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic up;
    logic down;
    logic any_en;
    logic hit;
    up = 1'b0;
    down = 1'b0;
    nxt_st = st_ff;
    any_en = en_latch_c_i | en_latch_rise_i | en_latch_fall_i;
    hit = st_ff.armed & ((en_latch_rise_i & gate_i & ~st_ff.gate_q) |
                         (en_latch_fall_i & ~gate_i & st_ff.gate_q) |
                         (en_latch_c_i & c_i & ~st_ff.c_q));
    if (cnt_mode_i) begin
      // Count on rising A, B high counts down
      if (a_i & ~st_ff.a_q) begin
        up = ~b_i;
        down = b_i;
      end
    end else begin
      // Quadrature: one step per A or B transition
      if ((a_i ^ st_ff.a_q) ^ (b_i ^ st_ff.b_q)) begin
        up = a_i ^ st_ff.b_q;
        down = b_i ^ st_ff.a_q;
      end
    end
    if (load_i) begin
      nxt_st.cnt = load_val_i;
    end else if (hit & clr_on_latch_i) begin
      nxt_st.cnt = '0;
    end else if (!lock_i) begin
      // A lock freezes the value; counting resumes from it
      if (up) begin
        nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
      end else if (down) begin
        nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
      end
    end
    // Arm when a latch source is enabled while none was enabled before, capture the first edge only
    if (any_en & ~st_ff.en_q) begin
      nxt_st.armed = 1'b1;
    end else if (!any_en) begin
      nxt_st.armed = 1'b0;
    end
    if (!any_en) begin
      nxt_st.latch_valid = 1'b0;
    end
    if (hit) begin
      nxt_st.latch = st_ff.cnt;
      nxt_st.latch_valid = 1'b1;
      nxt_st.armed = 1'b0;
    end
    nxt_st.en_q = any_en;
    nxt_st.a_q = a_i;
    nxt_st.b_q = b_i;
    nxt_st.c_q = c_i;
    nxt_st.gate_q = gate_i;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count_o = st_ff.cnt;
  assign latch_o = st_ff.latch;
  assign latch_valid_o = st_ff.latch_valid;

endmodule
`default_nettype wire

// ### bench/eccpi_top_properties.sv
// Purpose: Port checks for eccpi_top
// Assumes: Bound to every eccpi_top instance
// Notes: Control and lock copies mirror traffic seen at the ports
`timescale 1ns/1ps
`default_nettype none
`include "eccpi_params.svh"
module eccpi_top_properties #(
  parameter logic DUAL_VARIANT = 1'b0
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [`ECCPI_ADDR_W-1:0] reg_addr_i,
  input wire logic [`ECCPI_WORD_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`ECCPI_WORD_W-1:0] reg_rdata_o,
  input wire logic image_strobe_i,
  input wire logic [`ECCPI_OCTET_W-1:0] terminal_control_octet_i,
  input wire logic [`ECCPI_WORD_W-1:0] counter_preset_word_i,
  input wire logic [`ECCPI_OCTET_W-1:0] terminal_status_octet_o,
  input wire logic [`ECCPI_WORD_W-1:0] counter_readback_word_o,
  input wire logic full_image_o,
  input wire logic gate_i
);
  logic [`ECCPI_OCTET_W-1:0] ctrl_ff;
  logic [1:0] lock_ff;
  logic lock;
  logic rd_f;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ctrl_ff <= '0;
      lock_ff <= '0;
    end else begin
      ctrl_ff <= image_strobe_i ? terminal_control_octet_i : ctrl_ff;
      lock_ff <= (reg_wr_i && reg_addr_i == `ECCPI_FEATURE_ADDR) ? reg_wdata_i[5:4] : lock_ff;
    end
  end
  assign lock = (lock_ff[1] & gate_i) | (lock_ff[0] & ~gate_i);
  assign rd_f = reg_rd_i && reg_addr_i == `ECCPI_FEATURE_ADDR;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_full_single;
    !DUAL_VARIANT |-> full_image_o;
  endproperty
  a_full_single: assert property (p_full_single) else $error("single channel left full image");
  property p_feat_full;
    $past(rd_f) |-> reg_rdata_o[6] == $past(full_image_o);
  endproperty
  a_feat_full: assert property (p_feat_full) else $error("feature bit6 wrong");
  property p_feat_rsv;
    $past(rd_f) |-> (reg_rdata_o & ~32'h00008070) == 32'h0;
  endproperty
  a_feat_rsv: assert property (p_feat_rsv) else $error("feature spare bits set");
  property p_compact;
    $past(!full_image_o) |-> terminal_status_octet_o == 8'h00;
  endproperty
  a_compact: assert property (p_compact) else $error("status in compact image");
  property p_load;
    image_strobe_i && terminal_control_octet_i[2] && !terminal_control_octet_i[1] && !ctrl_ff[2] && full_image_o
      |=> ##2 counter_readback_word_o == $past(counter_preset_word_i, 3) && terminal_status_octet_o[2];
  endproperty
  a_load: assert property (p_load) else $error("preset not loaded");
  property p_lock;
    (lock && !image_strobe_i && $stable(gate_i))[*5] |-> $stable(counter_readback_word_o);
  endproperty
  a_lock: assert property (p_lock) else $error("locked counter moved");
  property p_echo;
    terminal_status_octet_o[1] == $past(full_image_o && ctrl_ff[1]);
  endproperty
  a_echo: assert property (p_echo) else $error("select echo wrong");
  property p_rd_live;
    $past(reg_rd_i && reg_addr_i == `ECCPI_COUNT_ADDR && !(full_image_o && ctrl_ff[1]))
      |-> reg_rdata_o == counter_readback_word_o;
  endproperty
  a_rd_live: assert property (p_rd_live) else $error("live word differs from count");
  c_load: cover property (image_strobe_i && terminal_control_octet_i[2] && full_image_o);
  c_lock: cover property (lock[*5]);
  c_feat: cover property (rd_f);
endmodule
bind eccpi_top eccpi_top_properties #(.DUAL_VARIANT(DUAL_VARIANT)) u_props (.*);
`default_nettype wire

// ### bench/eccpi_coupler.sv
// Purpose: Coupler model writing the output image
// Assumes: Called from the bench
// Notes: Lines show inverted data between strobes
`timescale 1ns/1ps
`default_nettype none
`include "eccpi_params.svh"
module eccpi_coupler (
  input wire logic mclk_i,
  output logic image_strobe_o,
  output logic [`ECCPI_OCTET_W-1:0] ctrl_o,
  output logic [`ECCPI_WORD_W-1:0] preset_o
);
  initial begin
    image_strobe_o = 1'b0;
    ctrl_o = 8'h00;
    preset_o = 32'h0;
  end
  task automatic send(input logic [7:0] c, input logic [31:0] p);
    @(posedge mclk_i);
    image_strobe_o <= 1'b1;
    ctrl_o <= c;
    preset_o <= p;
    @(posedge mclk_i);
    image_strobe_o <= 1'b0;
    ctrl_o <= ~c;
    preset_o <= ~p;
  endtask
endmodule
`default_nettype wire

// ### bench/eccpi_top_bench.sv
// Purpose: Self-checking bench for eccpi_top
// Assumes: Coupler model drives the output image
// Notes: Both variants share pins and register bus
`timescale 1ns/1ps
`default_nettype none
`include "eccpi_params.svh"
module eccpi_top_bench;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic a_i = 1'b0;
  logic b_i = 1'b0;
  logic c_i = 1'b0;
  logic gate_i = 1'b0;
  logic [31:0] reg_rdata_o, counter_preset_word_i, counter_readback_word_o, rv, exp_cnt, exp_lat;
  logic [7:0] terminal_control_octet_i, terminal_status_octet_o, dual_status;
  logic image_strobe_i, full_image_o, dual_full;
  logic [1:0] quad [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
  int mismatches = 0;
  int num_checks = 0;
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  eccpi_coupler u_coupler (.mclk_i, .image_strobe_o(image_strobe_i), .ctrl_o(terminal_control_octet_i),
    .preset_o(counter_preset_word_i));
  eccpi_top #(.DUAL_VARIANT(1'b0)) dut (.*);
  eccpi_top #(.DUAL_VARIANT(1'b1)) dut_dual (.*, .reg_rdata_o(), .terminal_status_octet_o(dual_status),
    .counter_readback_word_o(), .full_image_o(dual_full));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", w, e, g);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] ad);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    rv = reg_rdata_o;
  endtask
  task automatic pulse(input logic dn, input logic held);
    @(posedge mclk_i);
    b_i <= dn;
    @(posedge mclk_i);
    a_i <= 1'b1;
    @(posedge mclk_i);
    a_i <= 1'b0;
    if (!held) exp_cnt = dn ? exp_cnt - 1 : exp_cnt + 1;
  endtask
  task automatic chk_rb(input string w, input logic [31:0] e);
    repeat (4) @(posedge mclk_i);
    #1;
    chk(w, e, counter_readback_word_o);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h07602CA0));
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd(`ECCPI_FEATURE_ADDR);
    chk("feature", 32'h00000040, rv);
    chk("dual full", 32'h0, dual_full);
    $display("reset test done");
    exp_cnt = $urandom();
    u_coupler.send(8'h04, exp_cnt);
    chk_rb("load", exp_cnt);
    chk("load ack", 32'h1, terminal_status_octet_o[2]);
    chk("dual status", 32'h0, dual_status);
    u_coupler.send(8'h00, 32'h0);
    for (int i = 0; i < 8; i++) begin
      repeat (2) @(posedge mclk_i);
      {a_i, b_i} <= i < 4 ? quad[i] : quad[(10 - i) % 4];
      if (i % 4 == 3) begin
        exp_cnt = i < 4 ? exp_cnt + 4 : exp_cnt - 4;
        chk_rb("quadrature", exp_cnt);
      end
    end
    $display("quadrature test done");
    wr(`ECCPI_FEATURE_ADDR, 32'h00008000);
    rd(`ECCPI_FEATURE_ADDR);
    chk("feature", 32'h00008040, rv);
    repeat ($urandom_range(8, 3)) pulse(1'($urandom_range(1, 0)), 1'b0);
    chk_rb("up down", exp_cnt);
    for (int k = 0; k < 2; k++) begin
      wr(`ECCPI_FEATURE_ADDR, k ? 32'h00008010 : 32'h00008020);
      gate_i <= ~k[0];
      repeat (3) pulse(1'b0, 1'b1);
      chk_rb("locked", exp_cnt);
      @(posedge mclk_i);
      gate_i <= k[0];
      pulse(1'b1, 1'b0);
      chk_rb("resumed", exp_cnt);
    end
    $display("lock test done");
    wr(`ECCPI_FEATURE_ADDR, 32'h00008000);
    gate_i <= 1'b0;
    u_coupler.send(8'h08, $urandom());
    repeat (3) @(posedge mclk_i);
    gate_i <= 1'b1;
    exp_lat = exp_cnt;
    repeat (3) @(posedge mclk_i);
    pulse(1'b0, 1'b0);
    u_coupler.send(8'h0A, $urandom());
    chk_rb("latched", exp_lat);
    chk("status", 32'h3, terminal_status_octet_o[1:0]);
    rd(`ECCPI_LATCH_ADDR);
    chk("latch reg", exp_lat, rv);
    rd(`ECCPI_COUNT_ADDR);
    chk("count reg", exp_cnt, rv);
    u_coupler.send(8'h00, 32'h0);
    chk_rb("live", exp_cnt);
    // Falling gate edge latches and clears the counter; pin levels echo in status
    u_coupler.send(8'h30, $urandom());
    repeat (2) @(posedge mclk_i);
    gate_i <= 1'b0;
    c_i <= 1'b1;
    exp_lat = exp_cnt;
    exp_cnt = 32'h0000_0000;
    chk_rb("cleared", exp_cnt);
    chk("status pins", 32'h09, terminal_status_octet_o);
    rd(`ECCPI_LATCH_ADDR);
    chk("fall latch", exp_lat, rv);
    u_coupler.send(8'h00, 32'h0);
    $display("latch test done");
    wr(`ECCPI_FEATURE_ADDR, 32'h0);
    rd(`ECCPI_FEATURE_ADDR);
    chk("feature", 32'h00000040, rv);
    rd(6'h3F);
    chk("unmapped", 32'h0, rv);
    wr(`ECCPI_FEATURE_ADDR, 32'h00000040);
    #1;
    chk("dual full", 32'h1, dual_full);
    $display("image test done");
    stop_test();
  end
endmodule
`default_nettype wire
